// File: include/brf_cfg.svh
// Constants for the banked register file
`ifndef BRF_CFG_SVH
`define BRF_CFG_SVH
`define BRF_MODE_USR 5'h10
`define BRF_MODE_FIQ 5'h11
`define BRF_MODE_IRQ 5'h12
`define BRF_MODE_SVC 5'h13
`define BRF_MODE_ABT 5'h17
`define BRF_MODE_UND 5'h1B
`define BRF_MODE_SYS 5'h1F
`define BRF_SW_MODE_LSB 0
`define BRF_SW_STATE_INDICATOR_BIT 5
`define BRF_SW_FDIS 6
`define BRF_SW_IDIS 7
`define BRF_SW_FLAG_LSB 28
`define BRF_SW_RESET 32'h000000D3
`define BRF_VEC_RESET 32'h00000000
`define BRF_PC_RESET 32'h00000000
`define BRF_REG_PC 4'hF
`define BRF_REG_LR 4'hE
`define BRF_REG_SP 4'hD
`define BRF_REG_HI0 4'h8
`endif

// File: include/brf_pkg.sv
// Types shared by the banked register file
package brf_pkg;
    typedef enum logic [2:0] {
        BRF_BANK_USR = 3'h0,
        BRF_BANK_FIQ = 3'h1,
        BRF_BANK_IRQ = 3'h2,
        BRF_BANK_SVC = 3'h3,
        BRF_BANK_ABT = 3'h4,
        BRF_BANK_UND = 3'h5
    } brf_bank_t;

    // Control state machine: gray order run -> exception -> run
    typedef enum logic [1:0] {
        BRF_ST_RESET = 2'h0,
        BRF_ST_RUN = 2'h1,
        BRF_ST_EXC = 2'h3
    } brf_state_t;

    typedef struct packed {
        logic en;
        logic [3:0] idx;
        logic [31:0] data;
    } brf_wr_t;

    typedef struct packed {
        logic take;
        logic [4:0] mode;
        logic [31:0] vector;
        logic [31:0] ret_addr;
        logic mask_fiq;
    } brf_exc_t;
endpackage

// File: logic/brf_core_regs.sv
// Banked register file and state control of the core
`timescale 1ns/10ps
`include "brf_cfg.svh"

// Notes on behaviour
// - Wide state fetches word-aligned 32-bit instructions
// - Compact state uses 16-bit halfwords, PC bit 1
// - State switch keeps mode and all registers
// - Exchange branch: operand bit 0 selects state
// - Exception return restores prior compact state
// - Exception forces wide, saves PC, jumps vector
// - Big-endian: byte 0 on lines 31:24
// - Little-endian: byte 0 on lines 7:0
// - Word and halfword accesses must be aligned
// - Seven modes; all but user privileged
// - 31 general plus six status registers
// - Wide state sees 16 registers plus status
// - Link branch copies PC into register 14
// - PC low bits read zero per state
// - Fast interrupt banks registers 8 to 14
// - Other exception modes bank registers 13, 14
// - Compact low registers share wide copies
// - Compact hi registers only via special ops
// - One current, five saved status words
// - Mode field encodings; others illegal
// - State bit drives external indicator output
module brf_core_regs
    import brf_pkg::*;
#(
    // Register group sizes; the index decode is built for these
    parameter int unsigned LOW_REGS = 8,
    parameter int unsigned MID_REGS = 5,
    parameter int unsigned BANKS = 6
)
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // Register read ports
    input wire logic [3:0] rd_a_idx_in,
    input wire logic [3:0] rd_b_idx_in,
    output logic [31:0] rd_a_data_out,
    output logic [31:0] rd_b_data_out,
    input wire logic compact_hi_ok_in,
    // Register write port and PC update
    input wire brf_wr_t wr_in,
    input wire logic pc_load_in,
    input wire logic [31:0] pc_value_in,
    input wire logic pc_step_in,
    // Branch, exchange and link
    input wire logic branch_exchange_instr_in,
    input wire logic [31:0] bx_operand_in,
    input wire logic branch_with_link_instr_in,
    input wire logic [31:0] branch_target_in,
    // Exceptions
    input wire brf_exc_t exc_in,
    input wire logic exc_return_in,
    // Status word writes
    input wire logic sw_wr_in,
    input wire logic [31:0] sw_data_in,
    input wire logic ssw_wr_in,
    input wire logic [3:0] flags_in,
    input wire logic flags_wr_in,
    // Memory data steering
    input wire logic big_endian_in,
    input wire logic [1:0] mem_size_in,
    input wire logic [31:0] mem_addr_in,
    input wire logic [31:0] store_data_in,
    output logic [31:0] bus_wdata_out,
    output logic align_fault_out,
    // Core state
    output logic [31:0] fetch_addr_out,
    output logic halfword_sel_out,
    output logic state_indicator_bit_out,
    output logic privileged_out,
    output logic mode_illegal_out,
    output logic [31:0] current_status_word_out,
    output logic [31:0] saved_status_word_out
);
    logic [31:0] gpr_reg [0:LOW_REGS-1];
    logic [31:0] mid_reg [0:MID_REGS-1];
    logic [31:0] fiq_hi_reg [0:MID_REGS-1];
    logic [31:0] sp_reg [0:5];
    logic [31:0] lr_reg [0:5];
    logic [31:0] ssw_reg [1:5];
    logic [31:0] pc_reg;
    logic [31:0] pc_next;
    logic [31:0] csw_reg;
    logic [31:0] csw_next;
    brf_state_t state_reg;
    brf_state_t state_next;

    function automatic brf_bank_t bank_of(input logic [4:0] m);
        case (m)
            `BRF_MODE_FIQ: bank_of = BRF_BANK_FIQ;
            `BRF_MODE_IRQ: bank_of = BRF_BANK_IRQ;
            `BRF_MODE_SVC: bank_of = BRF_BANK_SVC;
            `BRF_MODE_ABT: bank_of = BRF_BANK_ABT;
            `BRF_MODE_UND: bank_of = BRF_BANK_UND;
            default: bank_of = BRF_BANK_USR;
        endcase
    endfunction

    // Only the seven listed encodings name a mode
    function automatic logic mode_legal(input logic [4:0] m);
        case (m)
            `BRF_MODE_USR, `BRF_MODE_FIQ, `BRF_MODE_IRQ, `BRF_MODE_SVC,
            `BRF_MODE_ABT, `BRF_MODE_UND, `BRF_MODE_SYS: mode_legal = 1'b1;
            default: mode_legal = 1'b0;
        endcase
    endfunction

    // Byte for one store lane, by access size
    function automatic logic [7:0] lane_byte(input logic [1:0] sz,
        input logic [31:0] d, input logic [1:0] ln);
        case (sz)
            2'h0: lane_byte = d[7:0];
            2'h1: lane_byte = ln[0] ? d[15:8] : d[7:0];
            default: lane_byte = d[8 * ln +: 8];
        endcase
    endfunction

    // Storage: 0..7 shared by all modes; 8..12 shared plus a fast
    // copy; 13 and 14 one copy per bank; PC and status words apart
    // Reads through the bank chosen now; PC reads with low bits cleared
    function automatic logic [31:0] read_reg(input logic [3:0] i,
        input brf_bank_t b, input logic [31:0] pcv);
        if (i == `BRF_REG_PC)
            read_reg = pcv;
        else if (i == `BRF_REG_LR)
            read_reg = lr_reg[b];
        else if (i == `BRF_REG_SP)
            read_reg = sp_reg[b];
        else if (i[3] && b == BRF_BANK_FIQ)
            read_reg = fiq_hi_reg[i[2:0]];
        else if (i[3])
            read_reg = mid_reg[i[2:0]];
        else
            read_reg = gpr_reg[i[2:0]];
    endfunction

    // Decoded view of the current status word; illegal modes fall
    // back to the user bank and raise mode_illegal_out instead
    wire [4:0] mode_w = csw_reg[`BRF_SW_MODE_LSB +: 5];
    wire brf_bank_t bank_w = bank_of(mode_w);
    wire compact_w = csw_reg[`BRF_SW_STATE_INDICATOR_BIT];
    wire legal_w = mode_legal(mode_w);
    wire user_w = mode_w == `BRF_MODE_USR;
    // System mode shares the user bank and so has no saved word
    wire has_ssw_w = bank_w != BRF_BANK_USR;

    // PC view: wide clears [1:0], compact clears [0]
    wire [31:0] pc_view_w = compact_w ? {pc_reg[31:1], 1'b0}
        : {pc_reg[31:2], 2'b00};
    wire [31:0] step_w = compact_w ? 32'h00000002 : 32'h00000004;
    // Step from the visible PC so stray low bits never carry on
    wire [31:0] pc_step_w = pc_view_w + step_w;

    // Compact state hides 8..15 unless decode vouches for the op;
    // decode raises compact_hi_ok_in for stack and hi moves alike
    wire hi_a_w = compact_w && rd_a_idx_in[3] && !compact_hi_ok_in;
    wire hi_b_w = compact_w && rd_b_idx_in[3] && !compact_hi_ok_in;
    wire hi_wr_w = compact_w && wr_in.idx[3] && !compact_hi_ok_in;
    wire wr_ok_w = wr_in.en && !hi_wr_w;
    wire wr_sp_w = wr_ok_w && wr_in.idx == `BRF_REG_SP;
    wire wr_lr_w = wr_ok_w && wr_in.idx == `BRF_REG_LR;

    // Exception target bank and status word requests
    wire brf_bank_t exc_bank_w = bank_of(exc_in.mode);
    wire ret_ok_w = exc_return_in && has_ssw_w;
    // Software may rewrite the status word only when privileged
    wire sw_ok_w = sw_wr_in && !user_w;

    // Memory steering decode
    wire [1:0] a_lo_w = mem_addr_in[1:0];
    wire word_w = mem_size_in == 2'h2;
    wire half_w = mem_size_in == 2'h1;

    // Banked reads before the compact hi-register gate
    wire [31:0] raw_a_w = read_reg(rd_a_idx_in, bank_w, pc_view_w);
    wire [31:0] raw_b_w = read_reg(rd_b_idx_in, bank_w, pc_view_w);

    assign rd_a_data_out = hi_a_w ? 32'h00000000 : raw_a_w;
    assign rd_b_data_out = hi_b_w ? 32'h00000000 : raw_b_w;
    assign fetch_addr_out = pc_view_w;
    assign halfword_sel_out = compact_w & pc_reg[1];
    assign state_indicator_bit_out = compact_w;
    assign privileged_out = !user_w;
    assign mode_illegal_out = !legal_w;
    assign current_status_word_out = csw_reg;
    assign saved_status_word_out = has_ssw_w ? ssw_reg[bank_w]
        : 32'h00000000;

    // Misaligned word or halfword accesses flagged for an abort
    assign align_fault_out = (word_w && a_lo_w != 2'h0)
        || (half_w && a_lo_w[0]);

    // A word leaves unchanged in either byte order: byte 0 already
    // rides 31:24 (big) or 7:0 (little), so big_endian_in only
    // matters to memory. Narrow stores go out on every lane.
    genvar li;
    generate
        for (li = 0; li < 4; li++) begin : g_lane
            assign bus_wdata_out[8 * li +: 8] =
                lane_byte(mem_size_in, store_data_in, 2'(li));
        end
    endgenerate

    // Status word: exception touches control bits only; return reloads the whole saved word
    // Priority: entry, return, exchange, software write, flags
    always_comb begin
        csw_next = csw_reg;
        if (state_reg == BRF_ST_RESET)
            csw_next = `BRF_SW_RESET;
        else if (exc_in.take) begin
            csw_next[`BRF_SW_MODE_LSB +: 5] = exc_in.mode;
            csw_next[`BRF_SW_STATE_INDICATOR_BIT] = 1'b0;
            csw_next[`BRF_SW_IDIS] = 1'b1;
            if (exc_in.mask_fiq)
                csw_next[`BRF_SW_FDIS] = 1'b1;
        end else if (ret_ok_w)
            csw_next = ssw_reg[bank_w];
        else if (branch_exchange_instr_in)
            csw_next[`BRF_SW_STATE_INDICATOR_BIT] = bx_operand_in[0];
        else if (sw_ok_w) begin
            // Software never alters the state bit itself
            csw_next = sw_data_in;
            csw_next[`BRF_SW_STATE_INDICATOR_BIT] = compact_w;
        end else if (flags_wr_in)
            csw_next[`BRF_SW_FLAG_LSB +: 4] = flags_in;
    end

    // PC: entry, exchange, link branch, load, then step
    always_comb begin
        pc_next = pc_reg;
        if (state_reg == BRF_ST_RESET)
            pc_next = `BRF_VEC_RESET;
        else if (exc_in.take)
            pc_next = exc_in.vector;
        else if (branch_exchange_instr_in)
            pc_next = {bx_operand_in[31:1], 1'b0};
        else if (branch_with_link_instr_in)
            pc_next = branch_target_in;
        else if (pc_load_in)
            pc_next = pc_value_in;
        else if (pc_step_in)
            pc_next = pc_step_w;
    end

    // The reset state re-forces the reset word and PC for one more
    // cycle, so a request in the first cycle after release is lost
    always_comb begin
        case (state_reg)
            BRF_ST_RESET: state_next = BRF_ST_RUN;
            BRF_ST_RUN: state_next = exc_in.take ? BRF_ST_EXC : BRF_ST_RUN;
            BRF_ST_EXC: state_next = exc_in.take ? BRF_ST_EXC : BRF_ST_RUN;
            // Unused code falls back to the reset state
            default: state_next = BRF_ST_RESET;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in)
            state_reg <= BRF_ST_RESET;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in)
            csw_reg <= `BRF_SW_RESET;
        else
            csw_reg <= csw_next;
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in)
            pc_reg <= `BRF_PC_RESET;
        else
            pc_reg <= pc_next;
    end

    // The index decode is wired for exactly this register split
    if (LOW_REGS != 8 || MID_REGS != 5 || BANKS != 6) begin : g_cfg_chk
        $error("unsupported register split");
    end

    // Shared low registers: identical in both states
    genvar gi;
    generate
        for (gi = 0; gi < LOW_REGS; gi++) begin : g_low
            always_ff @(posedge ref_clk_in) begin
                if (!rst_n_in)
                    gpr_reg[gi] <= 32'h00000000;
                else if (wr_ok_w && wr_in.idx == 4'(gi))
                    gpr_reg[gi] <= wr_in.data;
            end
        end

        // Registers 8..12: shared copy and fast-interrupt copy; a
        // write in fast mode never disturbs the shared copy
        for (gi = 0; gi < MID_REGS; gi++) begin : g_mid
            wire hit_w = wr_ok_w && wr_in.idx == 4'(gi + 8);
            wire fiq_w = hit_w && bank_w == BRF_BANK_FIQ;
            always_ff @(posedge ref_clk_in) begin
                if (!rst_n_in) begin
                    mid_reg[gi] <= 32'h00000000;
                    fiq_hi_reg[gi] <= 32'h00000000;
                end else if (fiq_w)
                    fiq_hi_reg[gi] <= wr_in.data;
                else if (hit_w)
                    mid_reg[gi] <= wr_in.data;
            end
        end

        // Stack and link per bank; fast bank uses same arrays. Entry
        // beats a link branch so the handler's return address holds.
        for (gi = 0; gi < BANKS; gi++) begin : g_bank
            wire cur_w = bank_w == brf_bank_t'(gi);
            wire exc_w = exc_in.take && exc_bank_w == brf_bank_t'(gi);
            wire bl_w = cur_w && branch_with_link_instr_in;
            wire sp_we_w = cur_w && wr_sp_w;
            wire lr_we_w = cur_w && wr_lr_w;
            always_ff @(posedge ref_clk_in) begin
                if (!rst_n_in) begin
                    sp_reg[gi] <= 32'h00000000;
                    lr_reg[gi] <= 32'h00000000;
                end else begin
                    if (sp_we_w)
                        sp_reg[gi] <= wr_in.data;
                    if (exc_w)
                        lr_reg[gi] <= exc_in.ret_addr;
                    else if (bl_w)
                        lr_reg[gi] <= pc_view_w;
                    else if (lr_we_w)
                        lr_reg[gi] <= wr_in.data;
                end
            end
        end

        // Five saved status words, one per exception mode
        for (gi = 1; gi < BANKS; gi++) begin : g_ssw
            wire load_w = exc_in.take && exc_bank_w == brf_bank_t'(gi);
            wire sw_w = ssw_wr_in && !exc_in.take
                && bank_w == brf_bank_t'(gi);
            always_ff @(posedge ref_clk_in) begin
                if (!rst_n_in)
                    ssw_reg[gi] <= 32'h00000000;
                else if (load_w)
                    ssw_reg[gi] <= csw_reg;
                else if (sw_w)
                    ssw_reg[gi] <= sw_data_in;
            end
        end
    endgenerate

    // Fast bank registers 13 and 14 live in sp_reg/lr_reg slot 1,
    // so the fast copy array only holds registers 8 to 12.
    // General: 8 low + 5 shared + 5 fast + 6 stack + 6 link + PC
    // = 31; status: 1 current + 5 saved.
endmodule

// File: tb/brf_core_regs_sva.sv
// Port-level checker for the banked register file
`timescale 1ns/10ps
module brf_core_regs_chk
    import brf_pkg::*;
(
    // Clock, reset and requests
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire brf_exc_t exc_in,
    input wire logic exc_return_in,
    input wire logic branch_exchange_instr_in,
    input wire logic [31:0] bx_operand_in,
    input wire logic branch_with_link_instr_in,
    input wire logic pc_load_in,
    input wire logic pc_step_in,
    // Memory steering
    input wire logic [1:0] mem_size_in,
    input wire logic [31:0] mem_addr_in,
    input wire logic [31:0] store_data_in,
    input wire logic [31:0] bus_wdata_out,
    input wire logic align_fault_out,
    // Core state
    input wire logic [31:0] fetch_addr_out,
    input wire logic halfword_sel_out,
    input wire logic state_indicator_bit_out,
    input wire logic privileged_out,
    input wire logic mode_illegal_out,
    input wire logic [31:0] current_status_word_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    wire [4:0] md = current_status_word_out[4:0];
    wire only_step = pc_step_in && !exc_in.take && !exc_return_in &&
        !branch_exchange_instr_in && !branch_with_link_instr_in &&
        !pc_load_in;

    exc_entry_a: assert property (exc_in.take |=>
        md == $past(exc_in.mode) && !state_indicator_bit_out &&
        fetch_addr_out == $past(exc_in.vector))
        else $error("exception entry wrong");
    bx_state_a: assert property (branch_exchange_instr_in &&
        !exc_in.take && !exc_return_in |=> $stable(md) &&
        state_indicator_bit_out == $past(bx_operand_in[0]))
        else $error("exchange branch state wrong");
    pc_step_a: assert property (only_step |=> fetch_addr_out ==
        $past(fetch_addr_out)
        + ($past(state_indicator_bit_out) ? 32'h2 : 32'h4))
        else $error("fetch step wrong");
    pc_low_a: assert property (!fetch_addr_out[0] &&
        (state_indicator_bit_out || !fetch_addr_out[1]))
        else $error("fetch low bits set");
    half_sel_a: assert property (halfword_sel_out ==
        (state_indicator_bit_out && fetch_addr_out[1]))
        else $error("halfword select wrong");
    state_pin_a: assert property (state_indicator_bit_out ==
        current_status_word_out[5]) else $error("state pin differs");
    priv_mode_a: assert property (!mode_illegal_out |->
        privileged_out == (md != 5'h10)) else $error("privilege wrong");
    mode_legal_a: assert property (mode_illegal_out == !(md inside
        {5'h10, 5'h11, 5'h12, 5'h13, 5'h17, 5'h1B, 5'h1F}))
        else $error("illegal mode flag wrong");
    align_chk_a: assert property (mem_size_in != 2'h3 |->
        align_fault_out == (mem_size_in == 2'h2 && mem_addr_in[1:0] != 2'h0
        || mem_size_in == 2'h1 && mem_addr_in[0]))
        else $error("alignment fault wrong");
    word_lane_a: assert property (mem_size_in == 2'h2 |->
        bus_wdata_out == store_data_in) else $error("word lanes wrong");
endmodule

bind brf_core_regs brf_core_regs_chk u_chk (.ref_clk_in, .rst_n_in,
    .exc_in, .exc_return_in, .branch_exchange_instr_in, .bx_operand_in,
    .branch_with_link_instr_in, .pc_load_in, .pc_step_in, .mem_size_in,
    .mem_addr_in, .store_data_in, .bus_wdata_out, .align_fault_out,
    .fetch_addr_out, .halfword_sel_out, .state_indicator_bit_out,
    .privileged_out, .mode_illegal_out, .current_status_word_out);

// File: tb/brf_mem_lane_model.sv
// Memory-side byte lane model for store data
`timescale 1ns/10ps
module brf_mem_lane_model (
    // Bus side
    input wire logic [31:0] wdata_in,
    input wire logic big_endian_in,
    input wire logic [1:0] addr_in,
    // Byte the memory keeps at that address
    output logic [7:0] byte_out
);
    wire [4:0] le_sh = {addr_in, 3'h0};
    wire [4:0] be_sh = {~addr_in, 3'h0};
    // Byte 0 on the top lane when big endian
    assign byte_out =
        8'(wdata_in >> (big_endian_in ? be_sh : le_sh));
endmodule

// File: tb/banked_register_file_bench.sv
// Self-checking bench for the banked register file
`timescale 1ns/10ps
module banked_register_file_bench;
    import brf_pkg::*;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [3:0] rd_a_idx_in, flags_in;
    logic compact_hi_ok_in, pc_step_in, branch_exchange_instr_in;
    logic branch_with_link_instr_in, exc_return_in, sw_wr_in;
    logic flags_wr_in, big_endian_in;
    logic [31:0] bx_operand_in, branch_target_in, sw_data_in;
    logic [31:0] mem_addr_in, store_data_in, rd_a_data_out, rd_b_data_out;
    logic [31:0] bus_wdata_out, fetch_addr_out, current_status_word_out;
    logic [31:0] saved_status_word_out;
    logic [1:0] mem_size_in, lane;
    brf_wr_t wr_in;
    brf_exc_t exc_in;
    logic align_fault_out, halfword_sel_out, state_indicator_bit_out;
    logic privileged_out, mode_illegal_out;
    logic [7:0] mem_byte;
    int fails = 0;
    int check_count = 0;
    int cycles = 0;

    brf_core_regs dut (.*, .rd_b_idx_in(4'hF), .ssw_wr_in(1'b0),
        .pc_load_in(1'b0), .pc_value_in(32'h0));
    brf_mem_lane_model mem (.wdata_in(bus_wdata_out),
        .big_endian_in(big_endian_in), .addr_in(lane), .byte_out(mem_byte));

    always #10 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        cycles++;
        // Run needs under a hundred cycles
        if (cycles == 3000) begin
            fails++;
            report_and_stop;
        end
    end

    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task cyc;
        @(posedge ref_clk_in);
    endtask
    task automatic rdchk(input logic [3:0] i, input logic [31:0] e);
        cyc;
        rd_a_idx_in <= i;
        #1 chk("register read", e, rd_a_data_out);
    endtask
    task automatic wreg(input logic [3:0] i, input logic [31:0] d);
        cyc;
        wr_in <= '{1'b1, i, d};
        cyc;
        wr_in.en <= 1'b0;
    endtask
    task automatic take(input logic [4:0] m, input logic [31:0] v, r);
        cyc;
        exc_in <= '{1'b1, m, v, r, 1'b1};
        cyc;
        exc_in.take <= 1'b0;
        #1;
    endtask
    task leave;
        cyc;
        exc_return_in <= 1'b1;
        cyc;
        exc_return_in <= 1'b0;
        #1;
    endtask
    task automatic bxc(input logic [31:0] v);
        cyc;
        branch_exchange_instr_in <= 1'b1;
        bx_operand_in <= v;
        cyc;
        branch_exchange_instr_in <= 1'b0;
        #1;
    endtask
    task stepc;
        cyc;
        pc_step_in <= 1'b1;
        cyc;
        pc_step_in <= 1'b0;
        #1;
    endtask
    task automatic swc(input logic [31:0] v);
        cyc;
        sw_wr_in <= 1'b1;
        sw_data_in <= v;
        cyc;
        sw_wr_in <= 1'b0;
        #1;
    endtask

    task t_bank;
        wreg(4'h8, 32'hAA);
        wreg(4'hD, 32'hBB);
        wreg(4'hE, 32'hCC);
        take(5'h11, 32'h1C, 32'h44);
        chk("status word", 32'hD1, current_status_word_out);
        chk("saved word", 32'hD3, saved_status_word_out);
        chk("fetch", 32'h1C, fetch_addr_out);
        rdchk(4'h8, 32'h0);
        rdchk(4'hE, 32'h44);
        wreg(4'h8, 32'hDD);
        take(5'h12, 32'h18, 32'h48);
        chk("saved word", 32'hD1, saved_status_word_out);
        rdchk(4'h8, 32'hAA);
        rdchk(4'hD, 32'h0);
        leave;
        rdchk(4'h8, 32'hDD);
        leave;
        rdchk(4'hD, 32'hBB);
        rdchk(4'hE, 32'hCC);
    endtask
    task t_state;
        bxc(32'h203);
        chk("status word", 32'hF3, current_status_word_out);
        chk("fetch", 32'h202, fetch_addr_out);
        chk("half select", 32'h1, 32'(halfword_sel_out));
        rdchk(4'h8, 32'h0);
        cyc;
        compact_hi_ok_in <= 1'b1;
        rdchk(4'h8, 32'hAA);
        rdchk(4'hD, 32'hBB);
        chk("pc read", 32'h202, rd_b_data_out);
        cyc;
        compact_hi_ok_in <= 1'b0;
        stepc;
        chk("fetch", 32'h204, fetch_addr_out);
        take(5'h17, 32'h10, 32'h206);
        chk("status word", 32'hD7, current_status_word_out);
        leave;
        chk("status word", 32'hF3, current_status_word_out);
        bxc(32'h300);
        stepc;
        chk("fetch", 32'h304, fetch_addr_out);
        cyc;
        branch_with_link_instr_in <= 1'b1;
        branch_target_in <= 32'h400;
        cyc;
        branch_with_link_instr_in <= 1'b0;
        #1 chk("fetch", 32'h400, fetch_addr_out);
        rdchk(4'hE, 32'h304);
    endtask
    task automatic t_lanes;
        logic [1:0] sz [5] = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h0};
        logic [1:0] ad [5] = '{2'h2, 2'h0, 2'h1, 2'h2, 2'h3};
        for (int e = 0; e < 2; e++) begin
            for (int k = 0; k < 4; k++) begin
                cyc;
                big_endian_in <= e[0];
                mem_size_in <= 2'h2;
                mem_addr_in <= 32'h0;
                store_data_in <= 32'h11223344;
                lane <= k[1:0];
                #1 chk("lane byte", (32'h11223344 >> (e ? 24 - 8 * k : 8 * k))
                    & 32'hFF, {24'h0, mem_byte});
            end
        end
        for (int t = 0; t < 5; t++) begin
            cyc;
            mem_size_in <= sz[t];
            mem_addr_in <= {30'h0, ad[t]};
            #1 chk("align fault", 32'(t == 0 || t == 2),
                32'(align_fault_out));
        end
    endtask
    task automatic t_modes;
        logic [4:0] md [7] = '{5'h11, 5'h12, 5'h13, 5'h17, 5'h1B, 5'h1F,
            5'h10};
        for (int i = 0; i < 7; i++) begin
            swc({24'h0, 3'b110, md[i]});
            chk("status word", {24'h0, 3'b110, md[i]},
                current_status_word_out);
            chk("privileged", 32'(md[i] != 5'h10),
                32'(privileged_out));
        end
        swc(32'hD3);
        chk("status word", 32'hD0, current_status_word_out);
        cyc;
        flags_wr_in <= 1'b1;
        flags_in <= 4'hA;
        cyc;
        flags_wr_in <= 1'b0;
        #1 chk("flags", 32'hA00000D0, current_status_word_out);
        cyc;
        rst_n_in <= 1'b0;
        repeat (2) cyc;
        rst_n_in <= 1'b1;
        repeat (2) cyc;
        swc(32'hC0);
        chk("illegal mode", 32'h1, 32'(mode_illegal_out));
    endtask

    initial begin
        {rd_a_idx_in, flags_in, compact_hi_ok_in, pc_step_in, exc_in,
            branch_exchange_instr_in, branch_with_link_instr_in, wr_in,
            exc_return_in, sw_wr_in, flags_wr_in, big_endian_in, lane,
            bx_operand_in, branch_target_in, sw_data_in, mem_addr_in,
            store_data_in, mem_size_in} = '0;
        repeat (2) cyc;
        rst_n_in <= 1'b1;
        repeat (2) cyc;
        #1 chk("status word", 32'hD3, current_status_word_out);
        chk("fetch", 32'h0, fetch_addr_out);
        t_bank;
        t_state;
        t_lanes;
        t_modes;
        report_and_stop;
    end
endmodule
